/* File: rtl/pcmhs_top.sv */
// pcm highway serial port: fixed and variable timing, standby and float control
`timescale 1ns/100ps
`include "pcmhs_defs.svh"

module pcmhs_top #(
  parameter logic [22:0] STANDBY_CYC = 23'(`PCMHS_STANDBY_CYC),
  parameter logic [16:0] PWRUP_CYC = 17'(`PCMHS_PWRUP_CYC)
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic link_clk_i,
  input wire logic power_down_n_i,
  input wire logic rx_bit_clock_negative_supply_i,
  input wire logic rx_bit_clock_i,
  input wire logic tx_bit_clock_i,
  input wire logic rx_frame_sync_i,
  input wire logic tx_frame_sync_i,
  input wire logic rx_pcm_in_i,
  input wire pcmhs_pkg::pcmhs_word_t tx_sample_i,
  output logic tx_load_o,
  output logic tx_pcm_out_o,
  output logic tx_pcm_oe_o,
  output logic tx_slot_strobe_n_o,
  output logic tx_slot_strobe_oe_o,
  output pcmhs_pkg::pcmhs_word_t rx_sample_o,
  output logic rx_valid_o,
  output logic fixed_mode_o,
  output logic tx_standby_o,
  output logic rx_standby_o,
  output logic active_o
);
  import pcmhs_pkg::*;

  // master clock silence count before the outputs float
  localparam logic [12:0] CLKSTOP_CYC = 13'(`PCMHS_CLKSTOP_CYC);
  localparam int SYNC_W = 9;

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // bit of a word sent at a given position, msb first
  function automatic logic bit_sel(input pcmhs_word_t w, input logic [2:0] i);
    bit_sel = w[`PCMHS_BIT_LAST - i];
  endfunction

  // one step of a standby timer: returns {standby, count}
  function automatic logic [23:0] idle_step(input logic fs,
                                            input pcmhs_cnt_t cnt,
                                            input logic sb,
                                            input pcmhs_cnt_t lim);
    idle_step = {sb, cnt};
    if (fs) begin
      idle_step = 24'h000000;
    end else if (cnt == lim - 23'h1) begin
      idle_step = {1'b1, cnt};
    end else begin
      idle_step = {sb, cnt + 23'h1};
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // link clock domain: master clock edges become toggles

  logic mr_tog_q; // flips on every master clock rise
  logic mf_tog_q; // flips on every master clock fall

  // rising edge toggle
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mr_tog_q <= 1'b0;
    end else begin
      mr_tog_q <= ~mr_tog_q;
    end
  end

  // falling edge toggle
  always_ff @(negedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mf_tog_q <= 1'b0;
    end else begin
      mf_tog_q <= ~mf_tog_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin and toggle synchronisers

  logic [SYNC_W-1:0] sy; // agreed copies of the outside pins and toggles, all but tx_sample_i

  pcmhs_sync #(
    .W(SYNC_W)
  ) u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .d_i({mr_tog_q, mf_tog_q, power_down_n_i,
          rx_bit_clock_negative_supply_i, rx_bit_clock_i, tx_bit_clock_i,
          rx_frame_sync_i, tx_frame_sync_i, rx_pcm_in_i}),
    .q_o(sy)
  );

  logic sy_mr, sy_mf, sy_pdn, sy_strap, sy_rxc, sy_txc, sy_rxfs, sy_txfs;
  logic sy_din;
  assign {sy_mr, sy_mf, sy_pdn, sy_strap, sy_rxc, sy_txc, sy_rxfs, sy_txfs,
          sy_din} = sy;

  //////////////////////////////////////////////////////////////////////////////
  // edge events

  pcmhs_state_s q_q; // registered state
  pcmhs_state_s d_d; // next state

  logic m_rise, m_fall, txc_rise, rxc_fall, txfs_rise, rxfs_rise;
  logic dev_en, tx_en, rx_en;
  logic [23:0] tx_step, rx_step;

  // master clock edges seen as toggle changes
  assign m_rise = sy_mr ^ q_q.mr_p;
  assign m_fall = sy_mf ^ q_q.mf_p;
  // data clocks: master clock in fixed mode, bit clocks otherwise
  assign txc_rise = q_q.fixed ? m_rise : (sy_txc & ~q_q.txc_p);
  assign rxc_fall = q_q.fixed ? m_fall : (~sy_rxc & q_q.rxc_p);
  assign txfs_rise = sy_txfs & ~q_q.txfs_p;
  assign rxfs_rise = sy_rxfs & ~q_q.rxfs_p;
  // device runs only when powered, settled and clocked
  assign dev_en = sy_pdn & q_q.pwrup_done & ~q_q.stopped;
  assign tx_en = dev_en & ~q_q.tx_sb;
  assign rx_en = dev_en & ~q_q.rx_sb;
  assign tx_step = idle_step(sy_txfs, q_q.tx_idle, q_q.tx_sb, STANDBY_CYC);
  assign rx_step = idle_step(sy_rxfs, q_q.rx_idle, q_q.rx_sb, STANDBY_CYC);

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    d_d = q_q;
    d_d.tx_load = 1'b0;
    d_d.rx_valid = 1'b0;
    // strapped rx clock pin means fixed timing
    d_d.fixed = sy_strap;
    d_d.txfs_p = sy_txfs;
    d_d.rxfs_p = sy_rxfs;
    d_d.txc_p = sy_txc;
    d_d.rxc_p = sy_rxc;
    d_d.mr_p = sy_mr;
    d_d.mf_p = sy_mf;

    // master clock watchdog
    if (m_rise || m_fall) begin
      d_d.stop_cnt = 13'h0000;
      d_d.stopped = 1'b0;
    end else if (q_q.stop_cnt == CLKSTOP_CYC - 13'h1) begin
      d_d.stopped = 1'b1;
    end else begin
      d_d.stop_cnt = q_q.stop_cnt + 13'h1;
    end

    // power-up settling, restarted by power down
    if (!sy_pdn) begin
      d_d.pwrup_cnt = 17'h00000;
      d_d.pwrup_done = 1'b0;
    end else if (!q_q.pwrup_done) begin
      if (q_q.pwrup_cnt == PWRUP_CYC - 17'h1) begin
        d_d.pwrup_done = 1'b1;
      end else begin
        d_d.pwrup_cnt = q_q.pwrup_cnt + 17'h1;
      end
    end

    // standby timers, one per channel
    {d_d.tx_sb, d_d.tx_idle} = tx_step;
    {d_d.rx_sb, d_d.rx_idle} = rx_step;

    // transmit slot sequencer
    if (!tx_en) begin
      d_d.tx_st = PCMHS_IDLE;
      d_d.tx_oe = 1'b0;
    end else begin
      case (q_q.tx_st)
        // a sync rise opens a slot and takes the sample
        PCMHS_IDLE: begin
          if (txfs_rise) begin
            d_d.tx_st = PCMHS_ARM;
            d_d.tx_word = tx_sample_i;
            d_d.tx_load = 1'b1;
          end
        end
        // first data clock rise drives the msb
        PCMHS_ARM: begin
          if (!q_q.fixed && !sy_txfs) begin
            d_d.tx_st = PCMHS_IDLE;
          end else if (txc_rise) begin
            d_d.tx_st = PCMHS_SHIFT;
            d_d.tx_oe = 1'b1;
            d_d.tx_bit = 3'h0;
            d_d.tx_out = bit_sel(q_q.tx_word, 3'h0);
          end
        end
        // further rises shift the remaining bits
        PCMHS_SHIFT: begin
          if (!q_q.fixed && !sy_txfs) begin
            d_d.tx_st = PCMHS_IDLE;
            d_d.tx_oe = 1'b0;
          end else if (txc_rise) begin
            if (q_q.tx_bit != `PCMHS_BIT_LAST) begin
              d_d.tx_bit = q_q.tx_bit + 3'h1;
              d_d.tx_out = bit_sel(q_q.tx_word, q_q.tx_bit + 3'h1);
            end else if (!q_q.fixed) begin
              d_d.tx_bit = 3'h0;
              d_d.tx_out = bit_sel(q_q.tx_word, 3'h0);
            end else begin
              d_d.tx_st = PCMHS_IDLE;
              d_d.tx_oe = 1'b0;
            end
          end
        end
        default: begin
          d_d.tx_st = PCMHS_IDLE;
          d_d.tx_oe = 1'b0;
        end
      endcase
    end
    // the strobe pin is an output only in fixed timing
    d_d.strobe_oe = d_d.tx_oe & q_q.fixed;

    // receive slot sequencer
    if (!rx_en) begin
      d_d.rx_st = PCMHS_IDLE;
    end else begin
      case (q_q.rx_st)
        // a sync rise opens the receive slot
        PCMHS_IDLE: begin
          if (rxfs_rise) begin
            d_d.rx_st = PCMHS_SHIFT;
            d_d.rx_bit = 3'h0;
          end
        end
        // each data clock fall takes one bit, msb first
        PCMHS_SHIFT: begin
          if (!q_q.fixed && !sy_rxfs) begin
            d_d.rx_st = PCMHS_IDLE;
          end else if (rxc_fall) begin
            d_d.rx_sh = {q_q.rx_sh[6:0], sy_din};
            d_d.rx_bit = q_q.rx_bit + 3'h1;
            if (q_q.rx_bit == `PCMHS_BIT_LAST) begin
              d_d.rx_word = {q_q.rx_sh[6:0], sy_din};
              d_d.rx_valid = 1'b1;
              d_d.rx_st = PCMHS_IDLE;
            end
          end
        end
        default: begin
          d_d.rx_st = PCMHS_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      q_q <= '0;
    end else begin
      q_q <= d_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  assign tx_load_o = q_q.tx_load;
  assign tx_pcm_out_o = q_q.tx_out;
  assign tx_pcm_oe_o = q_q.tx_oe;
  // open drain: only ever pulls low
  assign tx_slot_strobe_n_o = 1'b0;
  assign tx_slot_strobe_oe_o = q_q.strobe_oe;
  assign rx_sample_o = q_q.rx_word;
  assign rx_valid_o = q_q.rx_valid;
  assign fixed_mode_o = q_q.fixed;
  assign tx_standby_o = q_q.tx_sb;
  assign rx_standby_o = q_q.rx_sb;
  assign active_o = dev_en;

  //////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  pd_float_a: assert property (!sy_pdn |=> !tx_pcm_oe_o)
    else $error("tx output driven while powered down");
  mode_strap_a: assert property (sy_strap != fixed_mode_o |=>
    fixed_mode_o == $past(sy_strap))
    else $error("timing mode does not follow the strap");
  rx_word_a: assert property (rx_valid_o |->
    $past(rxc_fall) && rx_sample_o == $past({q_q.rx_sh[6:0], sy_din}))
    else $error("received word not taken on a clock fall");
  tx_msb_a: assert property (q_q.tx_st == PCMHS_ARM && txc_rise && tx_en
    && (q_q.fixed || sy_txfs) |=> tx_pcm_oe_o
    && tx_pcm_out_o == $past(q_q.tx_word[7]))
    else $error("msb not driven on first clock rise");
  tx_hold_a: assert property (q_q.tx_st == PCMHS_SHIFT && !txc_rise
    && tx_en && (q_q.fixed || sy_txfs) |=> $stable(tx_pcm_out_o)
    && tx_pcm_oe_o)
    else $error("tx bit changed between clock rises");
  rx_standby_a: assert property ($rose(rx_standby_o) |->
    $past(q_q.rx_idle) == STANDBY_CYC - 23'h1 && !$past(sy_rxfs))
    else $error("rx standby at wrong count");
  tx_standby_a: assert property (tx_standby_o |=> !tx_pcm_oe_o
    && !tx_slot_strobe_oe_o)
    else $error("tx output driven in standby");
  strobe_od_a: assert property (tx_slot_strobe_oe_o |->
    fixed_mode_o && tx_pcm_oe_o)
    else $error("strobe driven outside fixed slot");
  fixed_end_a: assert property (q_q.fixed && q_q.tx_st == PCMHS_SHIFT
    && q_q.tx_bit == 3'h7 && txc_rise && tx_en |=> !tx_pcm_oe_o)
    else $error("fixed slot longer than eight bits");
  tx_repeat_a: assert property (!q_q.fixed && q_q.tx_st == PCMHS_SHIFT
    && q_q.tx_bit == 3'h7 && txc_rise && tx_en && sy_txfs |=>
    tx_pcm_oe_o && tx_pcm_out_o == $past(q_q.tx_word[7]))
    else $error("variable mode word not repeated");
  pwrup_float_a: assert property (!q_q.pwrup_done |-> !tx_pcm_oe_o)
    else $error("tx output driven before settling");
  clk_stop_a: assert property ($rose(q_q.stopped) |->
    $past(q_q.stop_cnt) == CLKSTOP_CYC - 13'h1 ##1 !tx_pcm_oe_o)
    else $error("clock stop float wrong");

  fixed_rx_c: cover property (fixed_mode_o && rx_valid_o);
  var_rx_c: cover property (!fixed_mode_o && rx_valid_o);
  tx_repeat_c: cover property (!q_q.fixed && q_q.tx_st == PCMHS_SHIFT
    && q_q.tx_bit == 3'h7 && txc_rise && sy_txfs);
  standby_c: cover property ($rose(tx_standby_o));
endmodule

/* File: rtl/pcmhs_defs.svh */
// constants of the pcm highway serial port: sizes, resets and timing counts
`ifndef PCMHS_DEFS_SVH
`define PCMHS_DEFS_SVH

// system clock rate in mhz (5 ns period)
`define PCMHS_CLK_MHZ 200
// bits in one pcm sample word
`define PCMHS_WORD_BITS 8
// reset value of every sample word register
`define PCMHS_WORD_RST 8'h00
// index of the last bit of a word
`define PCMHS_BIT_LAST 3'h7
// frame sync low time that puts a channel into standby, in ms
`define PCMHS_STANDBY_MS 30
`define PCMHS_STANDBY_CYC (`PCMHS_STANDBY_MS * 1000 * `PCMHS_CLK_MHZ)
// output float time after power-up, four frames, in us
`define PCMHS_PWRUP_US 500
`define PCMHS_PWRUP_CYC (`PCMHS_PWRUP_US * `PCMHS_CLK_MHZ)
// master clock silence that floats the outputs, in us (longest time)
`define PCMHS_CLKSTOP_US 20
`define PCMHS_CLKSTOP_CYC (`PCMHS_CLKSTOP_US * `PCMHS_CLK_MHZ)

`endif

/* File: rtl/pcmhs_pkg.sv */
// types shared by the pcm highway serial port files
package pcmhs_pkg;
  // one companded pcm sample
  typedef logic [7:0] pcmhs_word_t;
  // long idle counters
  typedef logic [22:0] pcmhs_cnt_t;
  // slot sequencer states, gray coded along idle, arm, shift
  typedef enum logic [1:0] {
    PCMHS_IDLE  = 2'b00,
    PCMHS_ARM   = 2'b01,
    PCMHS_SHIFT = 2'b11
  } pcmhs_slot_e;
  // complete state of the serial port in the system clock domain
  typedef struct packed {
    pcmhs_slot_e tx_st;
    logic [2:0] tx_bit;
    pcmhs_word_t tx_word;
    logic tx_out;
    logic tx_oe;
    logic strobe_oe;
    logic tx_load;
    pcmhs_slot_e rx_st;
    logic [2:0] rx_bit;
    pcmhs_word_t rx_sh;
    pcmhs_word_t rx_word;
    logic rx_valid;
    pcmhs_cnt_t tx_idle;
    logic tx_sb;
    pcmhs_cnt_t rx_idle;
    logic rx_sb;
    logic [16:0] pwrup_cnt;
    logic pwrup_done;
    logic [12:0] stop_cnt;
    logic stopped;
    logic fixed;
    logic txfs_p;
    logic rxfs_p;
    logic txc_p;
    logic rxc_p;
    logic mr_p;
    logic mf_p;
  } pcmhs_state_s;
endpackage

/* File: rtl/pcmhs_sync.sv */
// three-stage synchroniser: a change passes once stages 2 and 3 agree
`timescale 1ns/100ps

module pcmhs_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  // stage registers and the agreed output
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } pcmhs_sync_s;

  pcmhs_sync_s q_q;
  pcmhs_sync_s d_d;

  //////////////////////////////////////////////////////////////////////////////
  // next state: each stage feeds the next, stage three included
  always_comb begin
    d_d = q_q;
    d_d.s1 = d_i;
    d_d.s2 = q_q.s1;
    d_d.s3 = q_q.s2;
    // take stage two where it agrees with stage three, else hold
    d_d.q = (q_q.s2 & ~(q_q.s2 ^ q_q.s3)) | (q_q.q & (q_q.s2 ^ q_q.s3));
  end

  // state register
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      q_q <= '0;
    end else begin
      q_q <= d_d;
    end
  end

  assign q_o = q_q.q;
endmodule

/* File: bench/pcmhs_highway_model.sv */
// highway controller model: master clock, bit clocks, syncs, rx data
`timescale 1ns/100ps

module pcmhs_highway_model (
  input wire logic clk_i,
  input wire logic link_run_i,
  input wire logic tx_pcm_out_i,
  input wire logic tx_pcm_oe_i,
  input wire logic tx_strobe_oe_i,
  output logic link_clk_o,
  output logic rx_bit_clock_o,
  output logic tx_bit_clock_o,
  output logic rx_frame_sync_o,
  output logic tx_frame_sync_o,
  output logic rx_pcm_o
);
  ////////////////////////////////////////////////////////////////////
  // master clock, 15 ns, halted only for the float test
  initial begin
    {link_clk_o, rx_bit_clock_o, tx_bit_clock_o} = 3'h0;
    {rx_frame_sync_o, tx_frame_sync_o, rx_pcm_o} = 3'h1;
    #3.1;
    forever begin
      #7.5;
      if (link_run_i) link_clk_o = ~link_clk_o;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // one rx word, msb first; data moves on the rise, read on the fall
  task automatic rx_word(input logic [7:0] w, input logic fx,
                         input int per);
    int i;
    if (fx) @(posedge link_clk_o);
    rx_frame_sync_o = 1'b1;
    if (!fx) #(per / 2.0);
    for (i = 7; i >= 0; i--) begin
      if (fx && i < 7) @(posedge link_clk_o);
      rx_pcm_o = w[i];
      if (fx) begin
        @(negedge link_clk_o);
      end else begin
        rx_bit_clock_o = 1'b1;
        #(per / 2.0);
        rx_bit_clock_o = 1'b0;
        #(per / 2.0);
      end
    end
    if (fx) @(posedge link_clk_o);
    rx_frame_sync_o = 1'b0;
    // released line has no pull: show the inverse, not the last bit
    rx_pcm_o = ~rx_pcm_o;
  endtask

  ////////////////////////////////////////////////////////////////////
  // one tx slot; bits sampled mid-bit on the system clock lattice
  task automatic tx_word(input logic fx, input int per, input int nb,
                         output logic [15:0] got, output logic ok);
    int i;
    int n;
    int p;
    got = 16'h0000;
    ok = 1'b1;
    p = fx ? 3 : per / 5;
    if (fx) @(negedge link_clk_o);
    tx_frame_sync_o = 1'b1;
    fork
      begin
        if (!fx) begin
          #(per / 2.0);
          repeat (nb) begin
            tx_bit_clock_o = 1'b1;
            #(per / 2.0);
            tx_bit_clock_o = 1'b0;
            #(per / 2.0);
          end
        end
      end
      begin
        n = 0;
        while (tx_pcm_oe_i !== 1'b1 && n < 200) begin
          @(negedge clk_i);
          n++;
        end
        for (i = 0; i < nb; i++) begin
          repeat (i == 0 ? p / 2 : p) @(negedge clk_i);
          got = {got[14:0], tx_pcm_out_i};
          if (tx_pcm_oe_i !== 1'b1 || tx_strobe_oe_i !== fx) ok = 1'b0;
        end
      end
    join
    repeat (p + 2) @(negedge clk_i);
    if (fx && tx_pcm_oe_i !== 1'b0) ok = 1'b0;
    tx_frame_sync_o = 1'b0;
    repeat (10) @(negedge clk_i);
    if (tx_pcm_oe_i !== 1'b0 || tx_strobe_oe_i !== 1'b0) ok = 1'b0;
  endtask
endmodule

/* File: bench/pcm_highway_serial_port_test.sv */
// self-checking bench for the pcm highway serial port
`timescale 1ns/100ps

module pcm_highway_serial_port_test;
  import pcmhs_pkg::*;
  // one slot pair: mode, bit period in ns, bits clocked, words
  typedef struct {
    logic fx;
    int per;
    int nb;
    pcmhs_word_t tx;
    pcmhs_word_t rx;
  } pcmhs_row_s;
  localparam int STBY = 1000;
  localparam int PWUP = 100;
  logic clk, reset, link_run, pdn_n, strap, link_clk, rx_clk, tx_clk;
  logic rx_fs, tx_fs, rx_dat, tx_out, tx_oe, stb_n, stb_oe, rx_valid;
  logic fixed_mode, tx_sb, rx_sb, active, tx_load, ok;
  pcmhs_word_t tx_sample, rx_sample, rx_got;
  logic [15:0] got, exp;
  int n_fail, samples_checked, loads, base;
  pcmhs_row_s rows [5] = '{
    '{1'b1, 15, 8, 8'ha5, 8'h3c},
    '{1'b1, 15, 8, 8'h80, 8'h01},
    '{1'b0, 40, 8, 8'h5a, 8'hc3},
    '{1'b0, 80, 16, 8'h96, 8'h69},
    '{1'b0, 40, 16, 8'h01, 8'h80}};
  // shared strobe pin: open drain low, else pull-up or the tx clock
  wire strobe_pin = stb_oe ? stb_n : (strap ? 1'b1 : tx_clk);

  ////////////////////////////////////////////////////////////////////
  pcmhs_top #(.STANDBY_CYC(23'(STBY)), .PWRUP_CYC(17'(PWUP))) u_pcmhs_top (
    .clk_i(clk), .reset_i(reset), .link_clk_i(link_clk),
    .power_down_n_i(pdn_n), .rx_bit_clock_negative_supply_i(strap),
    .rx_bit_clock_i(strap ? 1'b0 : rx_clk), .tx_bit_clock_i(strobe_pin),
    .rx_frame_sync_i(rx_fs), .tx_frame_sync_i(tx_fs),
    .rx_pcm_in_i(rx_dat), .tx_sample_i(tx_sample), .tx_load_o(tx_load),
    .tx_pcm_out_o(tx_out), .tx_pcm_oe_o(tx_oe),
    .tx_slot_strobe_n_o(stb_n), .tx_slot_strobe_oe_o(stb_oe),
    .rx_sample_o(rx_sample), .rx_valid_o(rx_valid),
    .fixed_mode_o(fixed_mode), .tx_standby_o(tx_sb),
    .rx_standby_o(rx_sb), .active_o(active));
  pcmhs_highway_model u_model (
    .clk_i(clk), .link_run_i(link_run), .tx_pcm_out_i(tx_out),
    .tx_pcm_oe_i(tx_oe), .tx_strobe_oe_i(stb_oe), .link_clk_o(link_clk),
    .rx_bit_clock_o(rx_clk), .tx_bit_clock_o(tx_clk),
    .rx_frame_sync_o(rx_fs), .tx_frame_sync_o(tx_fs), .rx_pcm_o(rx_dat));

  ////////////////////////////////////////////////////////////////////
  // count one comparison, report it when it went wrong
  task automatic tally(input logic bad, input string msg);
    samples_checked++;
    if (bad !== 1'b0) begin
      n_fail++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  // catch the one-cycle rx valid pulse, bounded
  task automatic wait_rx();
    rx_got = 8'hxx;
    for (int n = 0; n < 400; n++) begin
      @(negedge clk);
      if (rx_valid === 1'b1) begin
        rx_got = rx_sample;
        break;
      end
    end
  endtask
  task automatic wrap_up();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  // clocks, load counter and watchdog
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // counted on the falling edge, away from the launching edge, so the pulse is seen exactly once
  always @(negedge clk) if (tx_load === 1'b1) loads++;
  initial begin
    #200000;
    n_fail++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {reset, link_run, pdn_n, strap} = 4'hf;
    n_fail = 0;
    samples_checked = 0;
    loads = 0;
    tx_sample = 8'h00;
    repeat (16) @(negedge clk);
    tally(tx_oe !== 1'b0 || stb_oe !== 1'b0 || rx_valid !== 1'b0, "reset");
    reset = 1'b0;
    repeat (PWUP / 2) @(negedge clk);
    tally(active !== 1'b0, "active before settle");
    repeat (PWUP) @(negedge clk);
    tally(active !== 1'b1, "idle after settle");
    // ordinary slots, both modes, prompt and slow bit clocks
    foreach (rows[r]) begin
      strap = rows[r].fx;
      tx_sample = rows[r].tx;
      repeat (10) @(negedge clk);
      tally(fixed_mode !== rows[r].fx, "mode");
      exp = rows[r].nb == 16 ? {2{rows[r].tx}} : {8'h00, rows[r].tx};
      fork
        u_model.rx_word(rows[r].rx, rows[r].fx, rows[r].per);
        u_model.tx_word(rows[r].fx, rows[r].per, rows[r].nb, got, ok);
        wait_rx();
      join
      tally(got !== exp, "tx word");
      tally(ok !== 1'b1, "tx enables");
      tally(rx_got !== rows[r].rx, "rx word");
    end
    tally(loads != 5, "tx loads");
    // standby after a long sync silence, channels apart
    repeat (STBY - 100) @(negedge clk);
    tally(tx_sb !== 1'b0, "tx standby early");
    repeat (200) @(negedge clk);
    tally(tx_sb !== 1'b1 || rx_sb !== 1'b1, "no standby");
    u_model.tx_frame_sync_o = 1'b1;
    repeat (20) @(negedge clk);
    tally(tx_sb !== 1'b0 || rx_sb !== 1'b1, "standby split");
    u_model.tx_frame_sync_o = 1'b0;
    // power down refuses a slot, then settles again
    strap = 1'b1;
    pdn_n = 1'b0;
    base = loads;
    repeat (20) @(negedge clk);
    tally(active !== 1'b0, "powered");
    u_model.tx_frame_sync_o = 1'b1;
    ok = 1'b1;
    repeat (60) begin
      @(negedge clk);
      if (tx_oe !== 1'b0 || stb_oe !== 1'b0) ok = 1'b0;
    end
    u_model.tx_frame_sync_o = 1'b0;
    tally(ok !== 1'b1 || loads != base, "slot in power down");
    pdn_n = 1'b1;
    repeat (PWUP / 2) @(negedge clk);
    tally(active !== 1'b0, "active in settle");
    repeat (PWUP) @(negedge clk);
    tally(active !== 1'b1, "not active");
    // master clock stops: outputs float after the silence limit
    link_run = 1'b0;
    repeat (3900) @(negedge clk);
    tally(active !== 1'b1, "float too soon");
    repeat (200) @(negedge clk);
    tally(active !== 1'b0 || tx_oe !== 1'b0, "no float");
    link_run = 1'b1;
    repeat (100) @(negedge clk);
    wrap_up();
  end
endmodule
